// file: src/snvm_spi.v
// Operation
// R1: Select high: standby, ignore inputs, outputs off.
// R2: Select low enables clock edge reaction.
// R3: Host gives new select fall per opcode.
// R4: Capture on rising, shift out on falling.
// R5: Static; any clock rate, may stop.
// R6: Hold low freezes, ignores clock and select.
// R7: Host changes hold only with clock low.
// R8: Write-protect low blocks status writes only.
// R9: Data input sampled only at rising edges.
// R10: Output driven only during reads, else off.
// R11: Modes 0 and 3 both accepted.
// R12: Array is 32768 bytes of eight bits.
// R13: Each byte written at once, no busy.
// R14: Identity read returns maker and part code.
// R15: Tied data lines tolerated; drive only reads.
// R16: First byte after select is the opcode.
// R17: Eight-bit groups, most significant bit first.
// R18: Hold release resumes at same bit.
// R19: Select rising mid-byte aborts, no partial write.
`timescale 1ns/1ps
`include "snvm_consts.vh"
module snvm_spi #(
    parameter AW = `SNVM_ADDR_W,
    parameter DEPTH = `SNVM_DEPTH
) (
    input wire sys_clk,
    input wire resetn,
    input wire spi_clk,
    input wire sel_n,
    input wire hold_n,
    input wire wp_n,
    input wire sdi,
    output reg sdo,
    output wire sdo_oe,
    output wire [7:0] wr_byte,
    output wire wr_valid,
    input wire wr_ready
);
    ///////////////////////////////////////////////////////////////////////
    // Input synchronisers: every serial pin passes two flip-flops.
    reg [1:0] s_clk;
    reg [1:0] s_sel;
    reg [1:0] s_hold;
    reg [1:0] s_wp;
    reg [1:0] s_sdi;
    reg clk_d;
    reg sel_d;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_clk <= 2'h0;
            s_sel <= 2'h3;
            s_hold <= 2'h3;
            s_wp <= 2'h3;
            s_sdi <= 2'h0;
            clk_d <= 1'b0;
            sel_d <= 1'b1;
        end else begin
            s_clk <= {s_clk[0], spi_clk};
            s_sel <= {s_sel[0], sel_n};
            s_hold <= {s_hold[0], hold_n};
            s_wp <= {s_wp[0], wp_n};
            s_sdi <= {s_sdi[0], sdi};
            // Hold freezes the view of clock and select, so the sequencer
            // picks up at the same bit once the hold lifts. R6 R18
            if (s_hold[1]) begin
                clk_d <= s_clk[1];
                sel_d <= s_sel[1];
            end
        end
    end
    wire held = !s_hold[1];
    wire active = !s_sel[1] && !sel_d;
    // Edges seen only when selected and not held. R2 R6
    wire rise = active && !held && s_clk[1] && !clk_d;
    wire fall = active && !held && !s_clk[1] && clk_d;
    wire sel_fall = !held && !s_sel[1] && sel_d;
    wire sel_rise = !held && s_sel[1] && !sel_d;

    ///////////////////////////////////////////////////////////////////////
    // Storage and status.
    reg [7:0] mem [0:DEPTH-1]; // R12
    reg [7:0] status;
    localparam ST_OP = 6'h01;
    localparam ST_A1 = 6'h02;
    localparam ST_A2 = 6'h04;
    localparam ST_DUMMY = 6'h08;
    localparam ST_DATA = 6'h10;
    localparam ST_IDLE = 6'h20;
    reg [5:0] state;
    reg [7:0] op;
    reg [7:0] shin;
    reg [2:0] bitn;
    reg [AW-1:0] addr;
    reg [7:0] shout;
    reg reading;
    reg [2:0] idx;
    // One-cycle offer of a committed array byte to the output buffer.
    reg wr_push;
    reg [7:0] wr_data;
    reg did_write;
    wire [7:0] byte_in = {shin[6:0], s_sdi[1]}; // R17

    function is_read;
        input [7:0] c;
        begin
            is_read = (c == `SNVM_OP_READ) || (c == `SNVM_OP_FSTRD) ||
                (c == `SNVM_OP_RDSR) || (c == `SNVM_OP_RDID);
        end
    endfunction

    function [7:0] id_byte;
        input [2:0] i;
        begin
            id_byte = (i == 3'h0) ? `SNVM_ID_MAKER : `SNVM_ID_PART;
        end
    endfunction

    // Byte loaded for the next read slot.
    reg [7:0] next_out;
    always @* begin
        next_out = 8'h00;
        if (op == `SNVM_OP_RDSR) begin
            next_out = status;
        end else if (op == `SNVM_OP_RDID) begin
            next_out = id_byte(idx); // R14
        end else begin
            next_out = mem[addr];
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Command sequencer, clocked by sampled serial edges. Works from a
    // stopped clock because nothing moves without an edge. R5 R11
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            op <= 8'h00;
            shin <= 8'h00;
            bitn <= 3'h0;
            addr <= {AW{1'b0}};
            shout <= 8'h00;
            reading <= 1'b0;
            idx <= 3'h0;
            status <= `SNVM_SR_RESET;
            wr_push <= 1'b0;
            did_write <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            // The push is a single-cycle pulse per committed byte.
            wr_push <= 1'b0;
            if (sel_fall) begin
                // A fresh select starts a new opcode. R3 R16
                state <= ST_OP;
                bitn <= 3'h0;
                reading <= 1'b0;
                did_write <= 1'b0;
                idx <= 3'h0;
            end else if (sel_rise) begin
                // Partial byte is dropped; the latch clears after a write.
                state <= ST_IDLE; // R19
                reading <= 1'b0;
                if (did_write) begin
                    status[`SNVM_SR_WEL] <= 1'b0;
                end
            end else if (rise && state != ST_IDLE) begin
                shin <= byte_in; // R4 R9
                bitn <= bitn + 3'h1;
                if (bitn == 3'h7) begin
                    case (state)
                    ST_OP: begin
                        op <= byte_in;
                        state <= ST_IDLE;
                        if (byte_in == `SNVM_OP_WREN) begin
                            status[`SNVM_SR_WEL] <= 1'b1;
                        end else if (byte_in == `SNVM_OP_WRDI) begin
                            status[`SNVM_SR_WEL] <= 1'b0;
                        end else if (byte_in == `SNVM_OP_READ ||
                            byte_in == `SNVM_OP_FSTRD ||
                            byte_in == `SNVM_OP_WRITE) begin
                            state <= ST_A1;
                        end else if (byte_in == `SNVM_OP_RDSR ||
                            byte_in == `SNVM_OP_RDID ||
                            byte_in == `SNVM_OP_WRSR) begin
                            state <= ST_DATA;
                        end
                        reading <= (byte_in == `SNVM_OP_RDSR) ||
                            (byte_in == `SNVM_OP_RDID);
                    end
                    ST_A1: begin
                        addr <= {byte_in[AW-9:0], addr[7:0]};
                        state <= ST_A2;
                    end
                    ST_A2: begin
                        addr <= {addr[AW-1:8], byte_in};
                        state <= (op == `SNVM_OP_FSTRD) ? ST_DUMMY : ST_DATA;
                        reading <= (op == `SNVM_OP_READ);
                    end
                    ST_DUMMY: begin
                        state <= ST_DATA;
                        reading <= 1'b1;
                    end
                    ST_DATA: begin
                        if (op == `SNVM_OP_WRITE &&
                            status[`SNVM_SR_WEL]) begin
                            mem[addr] <= byte_in; // R13
                            did_write <= 1'b1;
                            wr_data <= byte_in;
                            wr_push <= 1'b1; // R13
                        end else if (op == `SNVM_OP_WRSR &&
                            status[`SNVM_SR_WEL] && s_wp[1]) begin
                            // Write-protect only guards status. R8
                            status <= (status & ~`SNVM_SR_WMASK) |
                                (byte_in & `SNVM_SR_WMASK);
                            did_write <= 1'b1;
                        end
                        if (op != `SNVM_OP_RDSR) begin
                            addr <= addr + {{(AW-1){1'b0}}, 1'b1};
                        end
                        if (idx != `SNVM_ID_LEN) begin
                            idx <= idx + 3'h1;
                        end
                    end
                    default: state <= ST_IDLE;
                    endcase
                end
            end
            // Output byte loads at the first falling edge of each slot.
            if (fall && reading) begin
                if (bitn == 3'h0) begin
                    shout <= {next_out[6:0], 1'b0};
                end else begin
                    shout <= {shout[6:0], 1'b0};
                end
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Serial output changes on falling edges, MSB first. R4 R17
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sdo <= 1'b0;
        end else if (fall && reading) begin
            sdo <= (bitn == 3'h0) ? next_out[7] : shout[7];
        end
    end
    // Driven only when reading, selected and not held. R1 R10 R15
    assign sdo_oe = reading && active && !held;

    ///////////////////////////////////////////////////////////////////////
    // Committed bytes pass a two-entry buffer, so a receiver that stalls
    // for a while loses nothing. Bytes arrive at most once per eight
    // serial clocks, so the buffer only fills if the receiver stalls for
    // longer than one whole byte; a byte offered then is lost.
    // It is never flushed: a byte already in the array must still be
    // reported even when the frame that wrote it has ended.
    snvm_buf #(
        .W(8)
    ) wbuf_u (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .flush(1'b0),
        .in_valid(wr_push),
        .in_ready(),
        .in_data(wr_data),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_byte)
    );
endmodule

// file: src/snvm_consts.vh
`ifndef SNVM_CONSTS_VH
`define SNVM_CONSTS_VH
// Command codes understood after the select falls.
`define SNVM_OP_WREN 8'h06
`define SNVM_OP_WRDI 8'h04
`define SNVM_OP_RDSR 8'h05
`define SNVM_OP_WRSR 8'h01
`define SNVM_OP_READ 8'h03
`define SNVM_OP_FSTRD 8'h0B
`define SNVM_OP_WRITE 8'h02
`define SNVM_OP_RDID 8'h9F
// Array geometry.
`define SNVM_ADDR_W 15
`define SNVM_DEPTH 32768
// Identity bytes; the values are arbitrary.
`define SNVM_ID_MAKER 8'h5A
`define SNVM_ID_PART 8'h21
// Status register: write-enable latch bit, writable mask, reset value.
`define SNVM_SR_WEL 1
`define SNVM_SR_WMASK 8'h8C
`define SNVM_SR_RESET 8'h00
// Byte and identity lengths.
`define SNVM_BYTE_W 8
`define SNVM_ID_LEN 3'h2
`endif

// file: src/snvm_buf.v
`timescale 1ns/1ps
`include "snvm_consts.vh"
module snvm_buf #(
    parameter W = 8
) (
    input wire sys_clk,
    input wire resetn,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:1];
    reg wp;
    reg rp;
    reg [1:0] cnt;
    wire push;
    wire pop;

    // Two entries; once both hold data in_ready falls and further input is refused.
    assign in_ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers and fill count; flush empties the buffer at once.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
        end else if (flush) begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
        end else begin
            if (push) begin
                wp <= ~wp;
            end
            if (pop) begin
                rp <= ~rp;
            end
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage needs no reset.
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
endmodule

// file: verification/snvm_spi_props.sv
`timescale 1ns/1ps
// Watches the serial pins and the write port of the memory interface.
module snvm_spi_props (
    input wire sys_clk,
    input wire resetn,
    input wire spi_clk,
    input wire sel_n,
    input wire hold_n,
    input wire wp_n,
    input wire sdi,
    input wire sdo,
    input wire sdo_oe,
    input wire [7:0] wr_byte,
    input wire wr_valid,
    input wire wr_ready
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // Pin levels must outlast the synchroniser before they count.
    sequence s_sel_idle;
        sel_n [*5];
    endsequence
    sequence s_clk_high;
        spi_clk [*3];
    endsequence
    // Output timing and tri-state behaviour.
    a_idle_quiet: assert property (s_sel_idle |-> !sdo_oe)
        else $error("output enabled while deselected");
    a_deselect_off: assert property ($rose(sel_n) |-> ##[0:4] !sdo_oe)
        else $error("output not released after deselect");
    a_hold_off: assert property ($fell(hold_n) |-> ##[1:5] !sdo_oe)
        else $error("output not released in suspend");
    a_hold_frozen: assert property (!hold_n [*6] |-> $stable(sdo))
        else $error("output moved during suspend");
    a_clk_high_sdo: assert property (s_clk_high |-> $stable(sdo))
        else $error("output moved while serial clock high");
    a_reset_idle: assert property ($rose(resetn) |-> !sdo_oe && !wr_valid)
        else $error("outputs active after reset");
    // Write port: a committed byte stays offered until taken.
    a_wr_held: assert property (wr_valid && !wr_ready |=>
        wr_valid && $stable(wr_byte))
        else $error("write byte dropped while stalled");
    a_commit_sel: assert property ($rose(wr_valid) |-> !sel_n)
        else $error("write committed outside a frame");
    a_commit_edge: assert property ($rose(wr_valid) |->
        spi_clk || $past(spi_clk))
        else $error("write committed away from a rising edge");
endmodule
bind snvm_spi snvm_spi_props props_u (.sys_clk(sys_clk), .resetn(resetn),
    .spi_clk(spi_clk), .sel_n(sel_n), .hold_n(hold_n), .wp_n(wp_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .wr_byte(wr_byte),
    .wr_valid(wr_valid), .wr_ready(wr_ready));

// file: verification/snvm_host.sv
`timescale 1ns/1ps
// Bus master model; all pins move on falling system clock edges.
module snvm_host (
    input wire sys_clk,
    input wire sdo,
    output logic spi_clk,
    output logic sel_n,
    output logic hold_n,
    output logic sdi
);
    logic mode3 = 1'b0;
    int pause_at = -1;
    // Idle pins; outside frames the serial clock moves only to set the next frame's idle level.
    initial begin
        spi_clk = 1'b0;
        sel_n = 1'b1;
        hold_n = 1'b1;
        sdi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic gap(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // A fresh select fall opens every frame, clock idling per mode.
    task automatic start(input logic m3);
        mode3 = m3;
        spi_clk = m3;
        gap(4);
        sel_n = 1'b0;
        gap(4);
    endtask
    // Bits go out MSB first; read bits are taken just before each rise.
    task automatic xfer(input logic [7:0] tx, input int nb,
                        output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            spi_clk = 1'b0;
            sdi = tx[i];
            gap(4);
            if (i == pause_at) begin
                hold_n = 1'b0;
                repeat (2) begin
                    gap(4);
                    spi_clk = 1'b1;
                    gap(4);
                    spi_clk = 1'b0;
                end
                gap(4);
                hold_n = 1'b1;
                gap(4);
            end
            rx[i] = sdo;
            spi_clk = 1'b1;
            gap(4);
        end
    endtask
    // The data line is flipped once released, so stale values never match.
    task automatic stop();
        spi_clk = mode3;
        gap(4);
        sel_n = 1'b1;
        sdi = ~sdi;
        gap(8);
    endtask
endmodule

// file: verification/snvm_spi_tb.sv
`timescale 1ns/1ps
`include "snvm_consts.vh"
module snvm_spi_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic wp_n = 1'b1;
    logic wr_ready = 1'b1;
    wire spi_clk, sel_n, hold_n, sdi, sdo, sdo_oe, wr_valid;
    wire [7:0] wr_byte;
    wire q_line = sdo_oe ? sdo : 1'bz;
    int errors = 0;
    int checks = 0;
    int seed = 10744;
    int cyc = 0;
    logic [7:0] rx;
    logic [7:0] taken = 8'h00;
    // The clock, a stalling receiver and the hang limit.
    always #10 sys_clk = ~sys_clk;
    always @(negedge sys_clk) wr_ready <= 1'($random(seed));
    // The write port only counts a byte at the handshake.
    always @(posedge sys_clk) if (wr_valid && wr_ready) taken <= wr_byte;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            close_out();
        end
    end
    snvm_spi dut_u (.sys_clk(sys_clk), .resetn(resetn), .spi_clk(spi_clk),
        .sel_n(sel_n), .hold_n(hold_n), .wp_n(wp_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .wr_byte(wr_byte), .wr_valid(wr_valid),
        .wr_ready(wr_ready));
    snvm_host host_u (.sys_clk(sys_clk), .sdo(q_line), .spi_clk(spi_clk),
        .sel_n(sel_n), .hold_n(hold_n), .sdi(sdi));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One frame: opcode, optional address, then nb data bits.
    task automatic frame(input logic [7:0] op, input int na,
                         input logic [14:0] a, input int nb,
                         inout logic [7:0] d);
        int r;
        r = $random(seed);
        host_u.start(r[0]);
        host_u.xfer(op, 8, rx);
        if (na > 0) begin
            host_u.xfer({r[1], a[14:8]}, 8, rx);
            host_u.xfer(a[7:0], 8, rx);
        end
        if (nb > 0) begin
            host_u.xfer(d, nb, rx);
            d = rx;
        end
        host_u.stop();
    endtask
    // Write then read back, with a suspend at a different bit each time.
    initial begin
        logic [14:0] a;
        logic [7:0] d;
        logic [7:0] v;
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        host_u.gap(4);
        check({7'h00, sdo_oe}, 8'h00);
        for (int k = 0; k < 8; k++) begin
            a = (k == 0) ? 15'h7FFF : 15'($random(seed));
            d = 8'($random(seed));
            wp_n = seed[2];
            v = d;
            frame(`SNVM_OP_WREN, 0, a, 0, v);
            frame(`SNVM_OP_WRITE, 2, a, 8, v);
            while (wr_valid) @(negedge sys_clk);
            check(taken, d);
            host_u.pause_at = k;
            frame(`SNVM_OP_READ, 2, a, 8, v);
            host_u.pause_at = -1;
            check(v, d);
        end
        // A byte cut short by deselect must leave the array alone.
        v = ~d;
        frame(`SNVM_OP_WREN, 0, a, 0, v);
        frame(`SNVM_OP_WRITE, 2, a, 4, v);
        frame(`SNVM_OP_READ, 2, a, 8, v);
        check(v, d);
        // Status writes are blocked by the protect pin only.
        wp_n = 1'b0;
        frame(`SNVM_OP_WREN, 0, a, 0, v);
        v = 8'hFF;
        frame(`SNVM_OP_WRSR, 0, a, 8, v);
        frame(`SNVM_OP_WRDI, 0, a, 0, v);
        frame(`SNVM_OP_RDSR, 0, a, 8, v);
        check(v, `SNVM_SR_RESET);
        wp_n = 1'b1;
        frame(`SNVM_OP_WREN, 0, a, 0, v);
        v = 8'hFF;
        frame(`SNVM_OP_WRSR, 0, a, 8, v);
        frame(`SNVM_OP_RDSR, 0, a, 8, v);
        check(v, `SNVM_SR_WMASK);
        // Identity gives the maker once, then the part code repeats.
        host_u.start(1'b0);
        host_u.xfer(`SNVM_OP_RDID, 8, rx);
        for (int j = 0; j < 3; j++) begin
            host_u.xfer(8'h00, 8, rx);
            check(rx, (j == 0) ? `SNVM_ID_MAKER : `SNVM_ID_PART);
        end
        host_u.stop();
        close_out();
    end
endmodule
